// *** dps_controller.sv ***
// Purpose: external controller; software drives the link pins over AXI4-Lite
// Assumes: single outstanding write and read
// Notes:   update and programming strobes are one-cycle pulses
`timescale 1ns/1ps
`include "dps_map.svh"
module dps_controller
  import dps_pkg::*;
(
  input  wire logic  core_clk,
  input  wire logic  resetn,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  dps_link_if.ctl          link
);
  logic [4:0]  waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        aw_have_reg;
  logic        w_have_reg;
  logic        wr_go;
  logic [31:0] ctrl_reg;
  logic [31:0] pdata_reg;
  logic [31:0] paddr_reg;
  logic [31:0] pwdata_reg;
  logic        upd_reg;
  logic        pwe_reg;

  // byte-lane merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    for (int b = 0; b < 4; b++)
      merge[b*8 +: 8] = st[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
  endfunction

  assign wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;

  // ************************************************************
  // write channel handshake
  // ************************************************************
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DPS_RESP_OKAY;
      waddr_reg     <= 5'h00;
      wdata_reg     <= 32'h00000000;
      wstrb_reg     <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        waddr_reg     <= s_axi_awaddr;
        aw_have_reg   <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
        w_have_reg   <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (waddr_reg > `DPS_R_PWDATA) ? `DPS_RESP_SLVERR : `DPS_RESP_OKAY;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ************************************************************
  // register effects and link pins
  // ************************************************************
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_reg   <= 32'h00000000;
      pdata_reg  <= 32'h00000000;
      paddr_reg  <= 32'h00000000;
      pwdata_reg <= 32'h00000000;
      upd_reg    <= 1'b0;
      pwe_reg    <= 1'b0;
    end
    else
    begin
      upd_reg <= 1'b0;
      pwe_reg <= 1'b0;
      if (wr_go)
      begin
        if (waddr_reg == `DPS_R_CTRL)
        begin
          ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg) & 32'h00000037;
          upd_reg  <= wstrb_reg[0] && wdata_reg[3];
        end
        else if (waddr_reg == `DPS_R_PDATA)
          pdata_reg <= merge(pdata_reg, wdata_reg, wstrb_reg) & 32'h0003FFFF;
        else if (waddr_reg == `DPS_R_PADDR)
          paddr_reg <= merge(paddr_reg, wdata_reg, wstrb_reg) & 32'h00000FFF;
        else if (waddr_reg == `DPS_R_PWDATA)
        begin
          pwdata_reg <= merge(pwdata_reg, wdata_reg, wstrb_reg);
          pwe_reg    <= 1'b1;
        end
      end
    end
  end

  assign link.profile_sel          = ctrl_reg[2:0];
  assign link.ramp_direction_input = ctrl_reg[4];
  assign link.ramp_freeze_input    = ctrl_reg[5];
  assign link.par_data             = pdata_reg[17:0];
  assign link.io_update            = upd_reg;
  assign link.prog_we              = pwe_reg;
  assign link.prog_addr            = paddr_reg[`DPS_PA_W-1:0];
  assign link.prog_wdata           = pwdata_reg;

  // ************************************************************
  // read channel
  // ************************************************************
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `DPS_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `DPS_RESP_OKAY;
      if (s_axi_araddr == `DPS_R_CTRL)
        s_axi_rdata <= ctrl_reg;
      else if (s_axi_araddr == `DPS_R_PDATA)
        s_axi_rdata <= pdata_reg;
      else if (s_axi_araddr == `DPS_R_PADDR)
        s_axi_rdata <= paddr_reg;
      else if (s_axi_araddr == `DPS_R_PWDATA)
        s_axi_rdata <= pwdata_reg;
      else if (s_axi_araddr == `DPS_R_STATUS)
        s_axi_rdata <= {31'h00000000, link.ramp_limit_flag};
      else
      begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `DPS_RESP_SLVERR;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // dps_controller

// *** dps_device.sv ***
// Purpose: selects and formats frequency, phase and amplitude for the synthesizer
// Assumes: link inputs synchronous to core_clk
// Notes:   outputs are registered so a new parameter set lands on one edge
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "dps_map.svh"
module dps_device
  import dps_pkg::*;
#(
  parameter int RAM_DEPTH = `DPS_RAM_DEPTH,
  parameter int NPROF     = `DPS_NPROF
)(
  input  wire logic   core_clk,
  input  wire logic   resetn,
  dps_link_if.dev     link,
  output logic [31:0] dds_ftw,
  output logic [15:0] dds_phase,
  output logic [13:0] dds_amp
);
  localparam int AW = $clog2(RAM_DEPTH);

  // ************************************************************
  // programming registers
  // ************************************************************
  logic [31:0] prof_ftw_reg [NPROF];
  logic [31:0] prof_pa_reg  [NPROF];
  logic [31:0] ram_prof_reg [NPROF];
  logic [31:0] ctl_reg;
  logic [31:0] upper_reg;
  logic [31:0] lower_reg;
  logic [31:0] rstep_reg;
  logic [31:0] fstep_reg;
  logic [31:0] rates_reg;
  logic [31:0] osk_reg;
  logic [31:0] ram_mem [RAM_DEPTH];

  // true when the write address falls in an eight-entry bank
  function automatic logic in_bank(input logic [`DPS_PA_W-1:0] a,
                                   input logic [`DPS_PA_W-1:0] base);
    in_bank = (a[`DPS_PA_W-1:3] == base[`DPS_PA_W-1:3]);
  endfunction

  // banked and single registers; memory writes are handled apart
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < NPROF; i++)
      begin
        prof_ftw_reg[i] <= 32'h00000000;
        prof_pa_reg[i]  <= 32'h00000000;
        ram_prof_reg[i] <= 32'h00000000;
      end
      ctl_reg   <= 32'h00000000;
      upper_reg <= 32'hFFFFFFFF;
      lower_reg <= 32'h00000000;
      rstep_reg <= 32'h00000000;
      fstep_reg <= 32'h00000000;
      rates_reg <= 32'h00000000;
      osk_reg   <= 32'h00000000;
    end
    else if (link.prog_we && !link.prog_addr[`DPS_RAM_SEL])
    begin
      if (in_bank(link.prog_addr, `DPS_A_FTW))
        prof_ftw_reg[link.prog_addr[2:0]] <= link.prog_wdata;
      else if (in_bank(link.prog_addr, `DPS_A_PHAMP))
        prof_pa_reg[link.prog_addr[2:0]] <= link.prog_wdata;
      else if (in_bank(link.prog_addr, `DPS_A_RPROF))
        ram_prof_reg[link.prog_addr[2:0]] <= link.prog_wdata;
      else if (link.prog_addr == `DPS_A_CTL)
        ctl_reg <= link.prog_wdata;
      else if (link.prog_addr == `DPS_A_UPPER)
        upper_reg <= link.prog_wdata;
      else if (link.prog_addr == `DPS_A_LOWER)
        lower_reg <= link.prog_wdata;
      else if (link.prog_addr == `DPS_A_RSTEP)
        rstep_reg <= link.prog_wdata;
      else if (link.prog_addr == `DPS_A_FSTEP)
        fstep_reg <= link.prog_wdata;
      else if (link.prog_addr == `DPS_A_RATES)
        rates_reg <= link.prog_wdata;
      else if (link.prog_addr == `DPS_A_OSK)
        osk_reg <= link.prog_wdata;
    end
  end

  // playback memory: no reset, contents only matter once written
  always_ff @(posedge core_clk)
  begin
    if (link.prog_we && link.prog_addr[`DPS_RAM_SEL])
      ram_mem[link.prog_addr[AW-1:0]] <= link.prog_wdata;
  end

  // ************************************************************
  // profile tracking
  // ************************************************************
  logic [2:0]  prof_seen_reg;
  logic        prof_chg;
  logic [31:0] rprof;
  logic [31:0] pa_sel;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      prof_seen_reg <= 3'h0;
    else
      prof_seen_reg <= link.profile_sel;
  end

  // the pin is used directly so a new profile reaches the outputs next edge
  assign prof_chg = (link.profile_sel != prof_seen_reg);
  assign rprof    = ram_prof_reg[link.profile_sel];
  assign pa_sel   = prof_pa_reg[link.profile_sel];

  // ************************************************************
  // ram playback
  // ************************************************************
  dps_ram_state_t ram_state_reg;
  logic [AW-1:0]  rd_addr_reg;
  logic [9:0]     ram_tmr_reg;
  logic [31:0]    ram_q_reg;
  logic           ram_on;

  // restarts from the start address on every update or profile change
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ram_state_reg <= ram_idle;
      rd_addr_reg   <= '0;
      ram_tmr_reg   <= 10'h000;
    end
    else if (!ctl_reg[`DPS_CTL_RAM_EN])
      ram_state_reg <= ram_idle;
    else if (link.io_update || prof_chg)
    begin
      ram_state_reg <= ram_play;
      rd_addr_reg   <= AW'(rprof[`DPS_RP_START]);
      ram_tmr_reg   <= 10'h000;
    end
    else
    begin
      case (ram_state_reg)
        ram_play:
        begin
          if (ram_tmr_reg == rprof[`DPS_RP_RATE])
          begin
            ram_tmr_reg <= 10'h000;
            if (rd_addr_reg == AW'(rprof[`DPS_RP_END]))
              ram_state_reg <= ram_hold;
            else
              rd_addr_reg <= rd_addr_reg + 1'b1;
          end
          else
            ram_tmr_reg <= ram_tmr_reg + 10'h001;
        end
        default: ram_state_reg <= ram_state_reg;
      endcase
    end
  end

  // synchronous read; the last word is held once the end is reached
  always_ff @(posedge core_clk)
  begin
    ram_q_reg <= ram_mem[rd_addr_reg];
  end

  assign ram_on = (ram_state_reg != ram_idle) && ctl_reg[`DPS_CTL_RAM_EN];

  // ************************************************************
  // ramp generator
  // ************************************************************
  logic [31:0] drg_acc_reg;
  logic [15:0] drg_tmr_reg;
  logic [15:0] drg_rate;
  logic        drg_on;
  logic        limit_reg;

  // one step toward a limit, landing on the limit instead of passing it
  function automatic logic [31:0] ramp_step(input logic [31:0] acc,
                                            input logic [31:0] step,
                                            input logic [31:0] lim,
                                            input logic        up);
    if (up)
      ramp_step = (acc >= lim || lim - acc <= step) ? lim : acc + step;
    else
      ramp_step = (acc <= lim || acc - lim <= step) ? lim : acc - step;
  endfunction

  assign drg_on   = ctl_reg[`DPS_CTL_DRG_EN];
  assign drg_rate = link.ramp_direction_input ? rates_reg[`DPS_RATE_RISE]
                                              : rates_reg[`DPS_RATE_FALL];

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      drg_acc_reg <= 32'h00000000;
      drg_tmr_reg <= 16'h0000;
    end
    else if (!drg_on)
    begin
      drg_acc_reg <= lower_reg;
      drg_tmr_reg <= 16'h0000;
    end
    else if (!link.ramp_freeze_input)
    begin
      if (drg_tmr_reg >= drg_rate)
      begin
        drg_tmr_reg <= 16'h0000;
        drg_acc_reg <= link.ramp_direction_input
                     ? ramp_step(drg_acc_reg, rstep_reg, upper_reg, 1'b1)
                     : ramp_step(drg_acc_reg, fstep_reg, lower_reg, 1'b0);
      end
      else
        drg_tmr_reg <= drg_tmr_reg + 16'h0001;
    end
  end

  // flag from the accumulator, one edge behind it
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      limit_reg <= 1'b0;
    else
      limit_reg <= drg_on && (drg_acc_reg == upper_reg ||
                              drg_acc_reg == lower_reg);
  end

  assign link.ramp_limit_flag = limit_reg;

  // ************************************************************
  // amplitude keying ramp
  // ************************************************************
  logic [13:0] osk_amp_reg;
  logic [15:0] osk_tmr_reg;
  logic [14:0] osk_sum;

  assign osk_sum = {1'b0, osk_amp_reg} + {1'b0, osk_reg[`DPS_OSK_STEP]};

  // rises linearly to the profile amplitude and stays there
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      osk_amp_reg <= 14'h0000;
      osk_tmr_reg <= 16'h0000;
    end
    else if (!ctl_reg[`DPS_CTL_OSK_EN])
    begin
      osk_amp_reg <= 14'h0000;
      osk_tmr_reg <= 16'h0000;
    end
    else if (osk_tmr_reg >= osk_reg[`DPS_OSK_RATE])
    begin
      osk_tmr_reg <= 16'h0000;
      osk_amp_reg <= (osk_sum >= {1'b0, pa_sel[`DPS_PA_AMP]}) ? pa_sel[`DPS_PA_AMP]
                                                              : osk_sum[13:0];
    end
    else
      osk_tmr_reg <= osk_tmr_reg + 16'h0001;
  end

  // ************************************************************
  // priority mux and output registers
  // ************************************************************
  logic [15:0] pd;
  logic [1:0]  pf;
  logic [1:0]  rdst;
  logic [1:0]  gdst;
  logic        par_on;
  logic [31:0] fm_off;
  logic [31:0] ftw_next;
  logic [15:0] phase_next;
  logic [13:0] amp_next;

  assign pd     = link.par_data[17:2];
  assign pf     = link.par_data[1:0];
  assign rdst   = rprof[`DPS_RP_DEST];
  assign gdst   = ctl_reg[`DPS_CTL_DRGDST];
  assign par_on = ctl_reg[`DPS_CTL_PAR_EN];
  // unsigned, zero extended, weighted by the gain shift
  assign fm_off = 32'({16'h0000, pd} << ctl_reg[`DPS_CTL_GAIN]);

  // each parameter falls through its sources in fixed order
  always_comb
  begin
    ftw_next   = prof_ftw_reg[link.profile_sel];
    phase_next = pa_sel[`DPS_PA_PHASE];
    amp_next   = pa_sel[`DPS_PA_AMP];
    if (ram_on && rdst == `DPS_DST_FREQ)
      ftw_next = ram_q_reg;
    else if (drg_on && gdst == `DPS_DST_FREQ)
      ftw_next = drg_acc_reg;
    else if (par_on && pf == `DPS_PF_FREQ)
      ftw_next = prof_ftw_reg[link.profile_sel] + fm_off;
    if (ram_on && (rdst == `DPS_DST_PHASE || rdst == `DPS_DST_POLAR))
      phase_next = ram_q_reg[31:16];
    else if (drg_on && gdst == `DPS_DST_PHASE)
      phase_next = drg_acc_reg[31:16];
    else if (par_on && pf == `DPS_PF_PHASE)
      phase_next = pd;
    else if (par_on && pf == `DPS_PF_POLAR)
      phase_next = {pd[7:0], pa_sel[23:16]};
    if (ctl_reg[`DPS_CTL_OSK_EN])
      amp_next = osk_amp_reg;
    else if (ram_on && rdst == `DPS_DST_AMP)
      amp_next = ram_q_reg[31:18];
    else if (ram_on && rdst == `DPS_DST_POLAR)
      amp_next = ram_q_reg[15:2];
    else if (drg_on && gdst == `DPS_DST_AMP)
      amp_next = drg_acc_reg[31:18];
    else if (par_on && pf == `DPS_PF_AMP)
      amp_next = pd[15:2];
    else if (par_on && pf == `DPS_PF_POLAR)
      amp_next = {pd[15:8], pa_sel[5:0]};
  end

  // all three land together on one edge
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dds_ftw   <= 32'h00000000;
      dds_phase <= 16'h0000;
      dds_amp   <= 14'h0000;
    end
    else
    begin
      dds_ftw   <= ftw_next;
      dds_phase <= phase_next;
      dds_amp   <= amp_next;
    end
  end
endmodule // dps_device

// *** dps_link_chk.sv ***
// Purpose: watches the link pins between the two ends
// Assumes: one clock, reset active low
// Notes:   only link pins are visible here
`timescale 1ns/1ps
`include "dps_map.svh"
module dps_link_chk (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic [2:0]  profile_sel,
  input wire logic [`DPS_PA_W-1:0] prog_addr,
  input wire logic        io_update,
  input wire logic        prog_we,
  input wire logic        ramp_freeze_input,
  input wire logic        ramp_limit_flag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // strobes are single cycle so one write is never seen twice
  a_update_one_pulse: assert property (io_update |=> !io_update)
    else $error("update pulse too long");
  a_prog_one_pulse: assert property (prog_we |=> !prog_we)
    else $error("program pulse too long");
  sequence s_frozen;
    (ramp_freeze_input && !prog_we) [*3];
  endsequence
  // a stalled ramp cannot cross a limit
  a_freeze_holds_flag: assert property (s_frozen |-> $stable(ramp_limit_flag))
    else $error("limit flag moved while frozen");
  // the address must already stand when its write strobe fires
  a_addr_before_write: assert property (prog_we |-> $stable(prog_addr))
    else $error("program address moved with its strobe");
  // an update and a programming write never share an edge
  a_update_not_write: assert property (io_update |-> !prog_we)
    else $error("update and program strobe together");
  sequence s_prof_moved;
    $changed(profile_sel);
  endsequence
  // a new profile choice holds for at least one more edge
  a_profile_settles: assert property (s_prof_moved |=> $stable(profile_sel))
    else $error("profile select changed twice in a row");
endmodule // dps_link_chk

// *** dps_link_if.sv ***
// Purpose: pins between the external controller and the device end
// Assumes: one clock, both ends sample on its rising edge
// Notes:   programming port is a one-cycle write strobe
`timescale 1ns/1ps
`include "dps_map.svh"
interface dps_link_if (input logic core_clk, input logic resetn);
  logic [2:0]             profile_sel;
  logic                   ramp_direction_input;
  logic                   ramp_freeze_input;
  logic [17:0]            par_data;
  logic                   io_update;
  logic                   prog_we;
  logic [`DPS_PA_W-1:0]   prog_addr;
  logic [31:0]            prog_wdata;
  logic                   ramp_limit_flag;
  modport dev (input profile_sel, ramp_direction_input, ramp_freeze_input, par_data,
               io_update, prog_we, prog_addr, prog_wdata, output ramp_limit_flag);
  modport ctl (output profile_sel, ramp_direction_input, ramp_freeze_input, par_data,
               io_update, prog_we, prog_addr, prog_wdata, input ramp_limit_flag);
endinterface // dps_link_if

// *** dps_map.svh ***
// Purpose: address, field and response constants for the parameter source mux
// Assumes: included by bare name from every design file except the shared types package
// Notes:   programming space is word indexed; bit 10 selects playback memory
`ifndef DPS_MAP_SVH
`define DPS_MAP_SVH

// ************************************************************
// programming space of the device end
// ************************************************************
`define DPS_PA_W       12
`define DPS_A_FTW      12'h000
`define DPS_A_PHAMP    12'h008
`define DPS_A_RPROF    12'h010
`define DPS_A_CTL      12'h018
`define DPS_A_UPPER    12'h019
`define DPS_A_LOWER    12'h01A
`define DPS_A_RSTEP    12'h01B
`define DPS_A_FSTEP    12'h01C
`define DPS_A_RATES    12'h01D
`define DPS_A_OSK      12'h01E
`define DPS_RAM_SEL    10
`define DPS_RAM_DEPTH  1024
`define DPS_NPROF      8

// ************************************************************
// field layouts
// ************************************************************
`define DPS_CTL_RAM_EN 0
`define DPS_CTL_DRG_EN 1
`define DPS_CTL_PAR_EN 2
`define DPS_CTL_OSK_EN 3
`define DPS_CTL_GAIN   7:4
`define DPS_CTL_DRGDST 9:8
`define DPS_RP_START   9:0
`define DPS_RP_END     19:10
`define DPS_RP_RATE    29:20
`define DPS_RP_DEST    31:30
`define DPS_PA_PHASE   31:16
`define DPS_PA_AMP     13:0
`define DPS_RATE_RISE  15:0
`define DPS_RATE_FALL  31:16
`define DPS_OSK_STEP   13:0
`define DPS_OSK_RATE   31:16
// destination codes: ram profiles and ramp generator
`define DPS_DST_FREQ   2'h0
`define DPS_DST_PHASE  2'h1
`define DPS_DST_AMP    2'h2
`define DPS_DST_POLAR  2'h3
// parallel destination word
`define DPS_PF_AMP     2'h0
`define DPS_PF_PHASE   2'h1
`define DPS_PF_FREQ    2'h2
`define DPS_PF_POLAR   2'h3

// ************************************************************
// controller register map (byte addresses)
// ************************************************************
`define DPS_R_CTRL     5'h00
`define DPS_R_PDATA    5'h04
`define DPS_R_PADDR    5'h08
`define DPS_R_PWDATA   5'h0C
`define DPS_R_STATUS   5'h10
`define DPS_RESP_OKAY  2'h0
`define DPS_RESP_SLVERR 2'h2
`endif

// *** dps_pkg.sv ***
// Purpose: shared types of the parameter source mux
// Assumes: nothing
// Notes:   numbers live in dps_map.svh
package dps_pkg;
  typedef enum logic [1:0] {ram_idle, ram_play, ram_hold} dps_ram_state_t;
endpackage

// *** testbench.sv ***
// Purpose: drives the controller over AXI4-Lite and checks the device outputs
// Assumes: 100 MHz clock, bounded waits
// Notes:   ramp limits kept small so the ramp settles fast
`timescale 1ns/1ps
`include "dps_map.svh"
module testbench;
  logic        core_clk = 0, resetn = 0;
  logic [4:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, frequency_tuning_word;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] rd;
  logic [15:0] phase;
  logic [13:0] amp;
  int          num_errors = 0, n_checks = 0, i;
  logic [31:0] rows [8] = '{32'h1, 32'h10, 32'hFF, 32'h1000,
                            32'h7FFFFFFF, 32'h80000000, 32'hFFFFFFFF, 32'h0A5A5A5A};
  always #5 core_clk = ~core_clk;
  dps_link_if link (.core_clk(core_clk), .resetn(resetn));
  dps_controller dps_controller_i (.core_clk(core_clk), .resetn(resetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link));
  dps_device dps_device_i (.core_clk(core_clk), .resetn(resetn), .link(link),
    .dds_ftw(frequency_tuning_word), .dds_phase(phase), .dds_amp(amp));
  dps_link_chk dps_link_chk_i (.core_clk(core_clk), .resetn(resetn),
    .profile_sel(link.profile_sel), .prog_addr(link.prog_addr),
    .io_update(link.io_update), .prog_we(link.prog_we),
    .ramp_freeze_input(link.ramp_freeze_input),
    .ramp_limit_flag(link.ramp_limit_flag));
  task conclude;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // each channel released at its own handshake; the wait is bounded
  task wr(input logic [4:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid) break;
    end
    rsp = bresp; bready <= 0;
    if (k == 50) begin num_errors++; conclude; end
  endtask
  task rdr(input logic [4:0] a);
    int k;
    @(posedge core_clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) break;
    end
    rd = rdata; rsp = rresp; rready <= 0;
    if (k == 50) begin num_errors++; conclude; end
  endtask
  task dev(input logic [11:0] idx, input logic [31:0] d);
    wr(`DPS_R_PADDR, {20'h0, idx});
    wr(`DPS_R_PWDATA, d);
    repeat (3) @(posedge core_clk);
  endtask
  initial
  begin
    repeat (10) @(posedge core_clk);
    resetn <= 1;
    chk("ftw reset", frequency_tuning_word, 32'h0);
    chk("phase reset", {16'h0, phase}, 32'h0);
    chk("amp reset", {18'h0, amp}, 32'h0);
    // one profile per row, selected through the profile pins
    for (i = 0; i < 8; i++)
    begin
      dev(12'(`DPS_A_FTW + i), rows[i]);
      wr(`DPS_R_CTRL, i);
      repeat (3) @(posedge core_clk);
      chk("profile ftw", frequency_tuning_word, rows[i]);
    end
    $display("profiles done");
    dev(`DPS_A_CTL, 32'h34);
    wr(`DPS_R_PDATA, 32'h48D2);
    repeat (3) @(posedge core_clk);
    chk("fm offset", frequency_tuning_word, rows[7] + (32'h1234 << 3));
    $display("parallel done");
    dev(`DPS_A_UPPER, 32'h100);
    dev(`DPS_A_RSTEP, 32'h80);
    dev(`DPS_A_FSTEP, 32'h80);
    wr(`DPS_R_CTRL, 32'h17);
    dev(`DPS_A_CTL, 32'h36);
    repeat (10) @(posedge core_clk);
    chk("ramp upper", frequency_tuning_word, 32'h100);
    rdr(`DPS_R_STATUS);
    chk("limit flag", rd, 32'h1);
    wr(`DPS_R_CTRL, 32'h27);
    repeat (10) @(posedge core_clk);
    chk("ramp frozen", frequency_tuning_word, 32'h100);
    wr(`DPS_R_CTRL, 32'h07);
    repeat (10) @(posedge core_clk);
    chk("ramp lower", frequency_tuning_word, 32'h0);
    $display("ramp done");
    // memory on frequency outranks both the ramp and the parallel offset
    dev(12'h400, 32'h13572468);
    dev(`DPS_A_CTL, 32'h37);
    wr(`DPS_R_CTRL, 32'h0F);
    repeat (5) @(posedge core_clk);
    chk("ram ftw", frequency_tuning_word, 32'h13572468);
    dev(12'(`DPS_A_PHAMP + 7), 32'hABCD1555);
    chk("profile phase", {16'h0, phase}, 32'hABCD);
    chk("profile amp", {18'h0, amp}, 32'h1555);
    // polar word: high byte to amplitude, low byte to phase
    wr(`DPS_R_PDATA, 32'h16B0F);
    repeat (3) @(posedge core_clk);
    chk("polar phase", {16'h0, phase}, 32'hC3CD);
    chk("polar amp", {18'h0, amp}, 32'h1695);
    // keying ramp climbs to the profile amplitude and beats the port
    dev(`DPS_A_OSK, 32'h1000);
    dev(`DPS_A_CTL, 32'h3F);
    repeat (5) @(posedge core_clk);
    chk("keying amp", {18'h0, amp}, 32'h1555);
    $display("sources done");
    rdr(5'h14);
    chk("unmapped resp", {30'h0, rsp}, 32'h2);
    chk("unmapped data", rd, 32'h0);
    wr(`DPS_R_STATUS, 32'h0);
    chk("status write", {30'h0, rsp}, 32'h2);
    $display("refusals done");
    conclude;
  end
endmodule // testbench
